// *** bench/span_props.sv ***
// Concurrent checks on the span joining line terminal and regenerator.
// Assumes it sits beside the span interface, on the one shared clock.
`timescale 1ns/100ps
`default_nettype none
module span_props (
	input wire logic       core_clk_in,
	input wire logic       rst_n_in,
	input wire logic       startup_sig,
	input wire logic       eoc_dn_valid,
	input wire logic [1:0] eoc_dn_addr,
	input wire logic [3:0] eoc_dn_code,
	input wire logic [7:0] ind_dn,
	input wire logic [1:0] pid_dn,
	input wire logic [7:0] data_dn,
	input wire logic       line_on,
	input wire logic       eoc_up_valid,
	input wire logic [1:0] eoc_up_addr,
	input wire logic [3:0] eoc_up_code,
	input wire logic [7:0] ind_up,
	input wire logic [1:0] pid_up,
	input wire logic [7:0] data_up
);
	// ----------------------------------------------------------------
	// Loop state rebuilt from the channel
	// ----------------------------------------------------------------
	logic loop_r;
	logic loop_nxt;
	wire  own_w  = eoc_dn_valid && line_on
		&& eoc_dn_addr == span_pkg::REG_ADDR;
	wire  frgn_w = eoc_dn_valid && line_on
		&& eoc_dn_addr != span_pkg::REG_ADDR;
	// Clears a cycle after shutdown; harmless, all checks that read loop_r need line_on
	assign loop_nxt = !line_on ? 1'b0 :
		(own_w && eoc_dn_code == span_pkg::CMD_LOOP1A) ? 1'b1 :
		(own_w && eoc_dn_code == span_pkg::CMD_NORMAL) ? 1'b0 : loop_r;
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in)
			loop_r <= 1'b0;
		else
			loop_r <= loop_nxt;
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_own_echo: assert property (
		own_w |=> eoc_up_valid && eoc_up_addr == span_pkg::REG_ADDR
		&& eoc_up_code == $past(eoc_dn_code))
		else $error("own address message not echoed");
	a_hold_reply: assert property (
		frgn_w && loop_r |=> eoc_up_valid
		&& eoc_up_code == span_pkg::CMD_HOLD
		&& eoc_up_addr == span_pkg::REG_ADDR)
		else $error("no hold reply in loop");
	a_frgn_pass: assert property (
		frgn_w && !loop_r |=> !eoc_up_valid)
		else $error("foreign message answered locally");
	a_loop_ind: assert property (
		line_on && $past(line_on) && $past(loop_r)
		|-> ind_up[3:0] == $past(ind_dn[3:0]))
		else $error("indicators not looped");
	a_loop_path: assert property (
		line_on && $past(line_on) && $past(loop_r)
		|-> pid_up == $past(pid_dn) && data_up == $past(data_dn))
		else $error("path not looped");
	a_wake_cause: assert property (
		$rose(line_on) |-> $past(startup_sig))
		else $error("wake without start-up signal");
	a_off_quiet: assert property (
		!line_on && !$past(line_on) |-> !eoc_up_valid && data_up == 8'h00)
		else $error("traffic while regenerator off");
	a_pid_valid: assert property (
		line_on && $past(line_on)
		|-> pid_up == span_pkg::PID_LT || pid_up == span_pkg::PID_NT)
		else $error("invalid path id toward line terminal");
	c_loop: cover property (own_w && eoc_dn_code == span_pkg::CMD_LOOP1A);
	c_hold: cover property (frgn_w && loop_r);
	c_wake: cover property ($rose(line_on));
	c_drop: cover property ($fell(line_on));
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Bench joining line terminal and regenerator controllers on one span.
// Assumes a shortened loss timer; registers reached over the plain port.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	// ----------------------------------------------------------------
	// Set-up
	// ----------------------------------------------------------------
	localparam int LOSS = 20;
	localparam int CEIL = 4000;
	typedef struct {logic [7:0] cmd; logic [7:0] rep; logic loop;} row_t;
	logic       core_clk_in;
	logic       rst_n_in = 1'b0;
	logic       wr = 1'b0, rd = 1'b0, lt_act = 1'b1, lt_loss = 1'b0;
	logic [3:0] addr = 4'h0, loss = 4'h0, reg_bits = 4'h0;
	logic [7:0] wdata = 8'h00, ind = 8'h00, data = 8'h00;
	logic [7:0] nt_ind = 8'h00, nt_data = 8'h00;
	logic [7:0] rdata, data_o, nt_data_o;
	logic       irq, nt_on, nt_st, loop;
	logic       nt_rst, nt_ev;
	logic [1:0] nt_ea, nt_pid_o;
	logic [3:0] nt_ec;
	logic [7:0] nt_ind_o, fwd = 8'h00;
	int         failures = 0, checks_done = 0, cyc = 0, n, resets = 0;
	row_t       rows [8] = '{
		'{8'h21, 8'h21, 1'b1}, '{8'h15, 8'h23, 1'b1}, '{8'h22, 8'h22, 1'b0},
		'{8'h15, 8'h22, 1'b0}, '{8'h23, 8'h23, 1'b0}, '{8'h21, 8'h21, 1'b1},
		'{8'h35, 8'h23, 1'b1}, '{8'h21, 8'h21, 1'b1}};
	span_if span_if_inst ();
	regen_ctrl #(.LOSS_CYCLES(32'(LOSS))) regen_ctrl_inst (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .span(span_if_inst),
		.lt_signal_loss_in(loss[0]), .lt_frame_alignment_loss_in(loss[1]),
		.nt_signal_loss_in(loss[2]), .nt_frame_alignment_loss_in(loss[3]),
		.lt_link_active_in(lt_act), .nt_link_active_in(1'b1),
		.reg_bits_in(reg_bits), .nt_ind_in(nt_ind), .nt_pid_in(2'h2),
		.nt_data_in(nt_data), .nt_eoc_valid_in(1'b0), .nt_eoc_addr_in(2'h0),
		.nt_eoc_code_in(4'h0), .nt_side_on_out(nt_on),
		.nt_xcvr_reset_out(nt_rst), .nt_startup_out(nt_st), .loop_out(loop),
		.nt_ind_out(nt_ind_o), .nt_pid_out(nt_pid_o),
		.nt_data_out(nt_data_o), .nt_eoc_valid_out(nt_ev),
		.nt_eoc_addr_out(nt_ea), .nt_eoc_code_out(nt_ec));
	line_term_ctrl #(.LOSS_CYCLES(32'(LOSS))) line_term_ctrl_inst (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .span(span_if_inst),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .irq_out(irq), .lt_signal_loss_in(lt_loss),
		.ind_in(ind), .data_in(data), .data_out(data_o));
	span_props span_props_inst (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.startup_sig(span_if_inst.startup_sig),
		.eoc_dn_valid(span_if_inst.eoc_dn_valid),
		.eoc_dn_addr(span_if_inst.eoc_dn_addr),
		.eoc_dn_code(span_if_inst.eoc_dn_code),
		.ind_dn(span_if_inst.ind_dn), .pid_dn(span_if_inst.pid_dn),
		.data_dn(span_if_inst.data_dn), .line_on(span_if_inst.line_on),
		.eoc_up_valid(span_if_inst.eoc_up_valid),
		.eoc_up_addr(span_if_inst.eoc_up_addr),
		.eoc_up_code(span_if_inst.eoc_up_code),
		.ind_up(span_if_inst.ind_up), .pid_up(span_if_inst.pid_up),
		.data_up(span_if_inst.data_up));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk8(input string nm, input logic [7:0] e,
		input logic [7:0] s);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic s);
		chk8(nm, {7'h00, e}, {7'h00, s});
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk_in);
		#1;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk_in);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input string nm, input logic [3:0] a,
		input logic [7:0] e);
		@(posedge core_clk_in);
		rd <= 1'b1;
		addr <= a;
		@(posedge core_clk_in);
		rd <= 1'b0;
		#1;
		chk8(nm, e, rdata);
	endtask
	task automatic complete_run();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Clock, watchdog and sequence
	// ----------------------------------------------------------------
	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end
	// Pulses are caught here so that later checks can see them
	always @(posedge core_clk_in) begin
		cyc++;
		if (nt_rst === 1'b1)
			resets++;
		if (nt_ev === 1'b1)
			fwd = {2'h0, nt_ea, nt_ec};
		if (cyc == CEIL) begin
			failures++;
			complete_run();
		end
	end
	initial begin
		repeat (3) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		wr_reg(span_pkg::REG_CTRL, 8'h01);
		for (n = 0; n < 20 && span_if_inst.line_on !== 1'b1; n++) tick(1);
		chk1("line on", 1'b1, span_if_inst.line_on);
		chk1("nt side", 1'b1, nt_on);
		foreach (rows[i]) begin
			wr_reg(span_pkg::REG_CMD, rows[i].cmd);
			tick(3);
			rd_chk("reply", span_pkg::REG_REPLY, rows[i].rep);
			chk1("loop", rows[i].loop, loop);
		end
		chk8("nt resets", 8'h02, 8'(resets));
		chk8("nt forward", 8'h15, fwd);
		// Looped: upper nibble must stay the regenerator's own bits
		@(posedge core_clk_in);
		ind <= 8'hA5;
		reg_bits <= 4'h6;
		data <= 8'h3C;
		nt_data <= 8'h77;
		tick(4);
		rd_chk("ind", span_pkg::REG_IND, 8'h65);
		chk8("looped data", 8'h3C, data_o);
		chk8("forwarded data", 8'h3C, nt_data_o);
		chk8("forwarded ind", 8'hA5, nt_ind_o);
		chk8("nt pid", {6'h00, span_pkg::PID_LT}, {6'h00, nt_pid_o});
		wr_reg(span_pkg::REG_CMD, 8'h22);
		for (n = 0; n < 8 && nt_st !== 1'b1; n++) tick(1);
		chk1("restart", 1'b1, nt_st);
		ind <= 8'h00;
		wr_reg(span_pkg::REG_STAT, 8'h1F);
		wr_reg(span_pkg::REG_MASK, 8'h02);
		nt_ind <= 8'h03;
		tick(4);
		rd_chk("stat", span_pkg::REG_STAT, 8'h06);
		chk1("irq", 1'b1, irq);
		wr_reg(span_pkg::REG_STAT, 8'h02);
		tick(2);
		chk1("irq", 1'b0, irq);
		rd_chk("stat", span_pkg::REG_STAT, 8'h04);
		wr_reg(span_pkg::REG_CMD, 8'h21);
		// Short burst must not trip the timer, a break restarts it
		loss <= 4'hF;
		tick(LOSS - 5);
		loss <= 4'h0;
		tick(2);
		chk1("still on", 1'b1, span_if_inst.line_on);
		@(posedge core_clk_in);
		loss <= 4'h8;
		lt_act <= 1'b0;
		for (n = 1; n < 40 && span_if_inst.line_on !== 1'b0; n++) tick(1);
		chk8("loss delay", 8'(LOSS + 2), 8'(n));
		tick(2);
		chk1("loop", 1'b0, loop);
		chk1("nt side", 1'b0, nt_on);
		lt_loss <= 1'b1;
		tick(LOSS + 5);
		rd_chk("ctrl", span_pkg::REG_CTRL, 8'h00);
		wr_reg(4'hF, 8'hFF);
		rd_chk("unmapped", 4'hF, 8'h00);
		@(posedge core_clk_in);
		rst_n_in <= 1'b0;
		tick(3);
		rst_n_in <= 1'b1;
		rd_chk("stat", span_pkg::REG_STAT, {3'h0, span_pkg::STAT_RESET});
		rd_chk("mask", span_pkg::REG_MASK, {3'h0, span_pkg::MASK_RESET});
		chk1("irq", 1'b0, irq);
		chk1("line on", 1'b0, span_if_inst.line_on);
		complete_run();
	end
endmodule
`default_nettype wire

// *** rtl/line_term_ctrl.sv ***
// Line terminal controller: software registers, start-up, loop check.
// Assumes a plain register port and a shared clock with the span.
`timescale 1ns/100ps
`default_nettype none
module line_term_ctrl #(
	parameter logic [31:0] LOSS_CYCLES = span_pkg::LOSS_CYCLES
) (
	input  wire logic                        core_clk_in,
	input  wire logic                        rst_n_in,
	span_if.lt_end                           span,
	input  wire logic [span_pkg::BUS_AW-1:0] addr_in,
	input  wire logic [span_pkg::BUS_DW-1:0] wdata_in,
	input  wire logic                        wr_in,
	input  wire logic                        rd_in,
	output var  logic [span_pkg::BUS_DW-1:0] rdata_out,
	output var  logic                        irq_out,
	input  wire logic                        lt_signal_loss_in,
	input  wire logic [span_pkg::IND_W-1:0]  ind_in,
	input  wire logic [span_pkg::DATA_W-1:0] data_in,
	output var  logic [span_pkg::DATA_W-1:0] data_out
);
	logic [7:0]                  ctrl_r;
	logic [span_pkg::STAT_W-1:0] stat_r;
	logic [span_pkg::STAT_W-1:0] mask_r;
	logic [7:0]                  reply_r;
	logic                        loop_req_r;
	logic                        pid_ok_r;
	logic [1:0]                  ps_r;
	logic                        loss_fire;

	loss_timer #(
		.CYCLES (LOSS_CYCLES)
	) u_loss (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.cond_in     (lt_signal_loss_in),
		.expired_out (loss_fire)
	);

	// ----------------------------------------------------------------
	// Decode and events
	// ----------------------------------------------------------------
	wire wr_cmd  = wr_in && addr_in == span_pkg::REG_CMD;
	wire wr_stat = wr_in && addr_in == span_pkg::REG_STAT;
	wire [3:0] cmd_code = wdata_in[3:0];
	wire pid_ok  = loop_req_r && span.pid_up == span_pkg::PID_LT; // [RL8]
	wire [1:0] ps_now = {span.ind_up[span_pkg::PS2_BIT],
		span.ind_up[span_pkg::PS1_BIT]}; // [RL14]
	wire [span_pkg::STAT_W-1:0] set_ev = {loss_fire, span.eoc_up_valid,
		ps_now & ~ps_r, pid_ok && !pid_ok_r};
	wire [span_pkg::STAT_W-1:0] clr_ev = wr_stat
		? wdata_in[span_pkg::STAT_W-1:0] : '0;
	// Set wins over a clear in the same cycle
	wire [span_pkg::STAT_W-1:0] stat_nxt = (stat_r & ~clr_ev) | set_ev;
	wire [7:0] rd_mux =
		addr_in == span_pkg::REG_CTRL  ? ctrl_r :
		addr_in == span_pkg::REG_STAT  ? {3'h0, stat_r} :
		addr_in == span_pkg::REG_MASK  ? {3'h0, mask_r} :
		addr_in == span_pkg::REG_REPLY ? reply_r :
		addr_in == span_pkg::REG_IND   ? span.ind_up : 8'h00;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			ctrl_r    <= span_pkg::CTRL_RESET;
			stat_r    <= span_pkg::STAT_RESET;
			mask_r    <= span_pkg::MASK_RESET;
			reply_r   <= 8'h00;
			rdata_out <= 8'h00;
			irq_out   <= 1'b0;
			pid_ok_r  <= 1'b0;
			ps_r      <= 2'h0;
		end else begin
			if (loss_fire) begin
				ctrl_r[span_pkg::CTRL_START] <= 1'b0; // [RL1]
			end else if (wr_in && addr_in == span_pkg::REG_CTRL) begin
				ctrl_r <= wdata_in;
			end
			if (wr_in && addr_in == span_pkg::REG_MASK) begin
				mask_r <= wdata_in[span_pkg::STAT_W-1:0];
			end
			if (span.eoc_up_valid) begin
				reply_r <= {2'h0, span.eoc_up_addr, span.eoc_up_code};
			end
			stat_r    <= stat_nxt;
			irq_out   <= |(stat_nxt & mask_r);
			rdata_out <= rd_in ? rd_mux : 8'h00;
			pid_ok_r  <= pid_ok;
			ps_r      <= ps_now;
		end
	end

	// ----------------------------------------------------------------
	// Span drive
	// ----------------------------------------------------------------
	// Loop command is meant to follow the first start-up signal
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			span.startup_sig  <= 1'b0;
			span.eoc_dn_valid <= 1'b0;
			span.eoc_dn_addr  <= '0;
			span.eoc_dn_code  <= '0;
			span.ind_dn       <= '0;
			span.pid_dn       <= '0;
			span.data_dn      <= '0;
			data_out          <= '0;
			loop_req_r        <= 1'b0;
		end else begin
			span.startup_sig  <= ctrl_r[span_pkg::CTRL_START]
				&& !loss_fire; // [RL5]
			span.eoc_dn_valid <= wr_cmd; // [RL3]
			span.eoc_dn_addr  <= wdata_in[span_pkg::CMD_ADDR_LO+:2];
			span.eoc_dn_code  <= cmd_code;
			span.ind_dn       <= ind_in;
			span.pid_dn       <= span_pkg::PID_LT;
			span.data_dn      <= data_in;
			data_out          <= span.data_up;
			if (loss_fire) begin
				loop_req_r <= 1'b0;
			end else if (wr_cmd && cmd_code == span_pkg::CMD_LOOP1A) begin
				loop_req_r <= 1'b1; // [RL4]
			end else if (wr_cmd && cmd_code == span_pkg::CMD_NORMAL) begin
				loop_req_r <= 1'b0; // [RL12]
			end
		end
	end
endmodule
`default_nettype wire

// *** rtl/loss_timer.sv ***
// Persistence timer for signal or frame-alignment loss.
// Assumes cond_in is synchronous; fires one pulse per unbroken loss.
`timescale 1ns/100ps
`default_nettype none
module loss_timer #(
	parameter logic [31:0] CYCLES = span_pkg::LOSS_CYCLES
) (
	input  wire logic core_clk_in,
	input  wire logic rst_n_in,
	input  wire logic cond_in,
	output var  logic expired_out
);
	logic [31:0] cnt_r;
	logic        done_r;
	wire         at_end = cnt_r == CYCLES - 32'h1;

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	// Saturates at CYCLES - 1; done_r makes one loss give exactly one pulse
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || !cond_in) begin
			cnt_r       <= 32'h0;
			done_r      <= 1'b0;
			expired_out <= 1'b0;
		end else begin
			if (!at_end) begin
				cnt_r <= cnt_r + 32'h1;
			end
			expired_out <= at_end && !done_r; // [RL1]
			done_r      <= done_r || at_end;
		end
	end
endmodule
`default_nettype wire

// *** rtl/regen_ctrl.sv ***
// Regenerator control unit: loss shutdown and loopback 1A handling.
// Assumes loss flags and link states come from its own transceivers.
//
// Summary of operation
// [RL1] Path deactivated two seconds after loss
// [RL2] Loss on either side drops both sides
// [RL3] Line terminal starts loopback by addressed message
// [RL4] Loopback accepted at start-up or active
// [RL5] Command after first start-up signal closes loop
// [RL6] Active link: close loop, reset customer side
// [RL7] Loopback transparent; still forwarded toward network
// [RL8] Line terminal confirms loop via path id
// [RL9] Channel not looped; served for own address
// [RL10] Foreign address in loop: hold-state reply
// [RL11] Indicators looped except four regenerator bits
// [RL12] Return-to-normal drops customer side, ends loop
// [RL13] Then restart network side if line active
// [RL14] Power source failures reported on two bits
// [RL15] Single loop flag cleared by loss shutdown
`timescale 1ns/100ps
`default_nettype none
module regen_ctrl #(
	parameter logic [31:0] LOSS_CYCLES = span_pkg::LOSS_CYCLES
) (
	input  wire logic                        core_clk_in,
	input  wire logic                        rst_n_in,
	span_if.reg_end                          span,
	input  wire logic                        lt_signal_loss_in,
	input  wire logic                        lt_frame_alignment_loss_in,
	input  wire logic                        nt_signal_loss_in,
	input  wire logic                        nt_frame_alignment_loss_in,
	input  wire logic                        lt_link_active_in,
	input  wire logic                        nt_link_active_in,
	input  wire logic [3:0]                  reg_bits_in,
	input  wire logic [span_pkg::IND_W-1:0]  nt_ind_in,
	input  wire logic [span_pkg::PID_W-1:0]  nt_pid_in,
	input  wire logic [span_pkg::DATA_W-1:0] nt_data_in,
	input  wire logic                        nt_eoc_valid_in,
	input  wire logic [span_pkg::ADDR_W-1:0] nt_eoc_addr_in,
	input  wire logic [span_pkg::CODE_W-1:0] nt_eoc_code_in,
	output var  logic                        nt_side_on_out,
	output var  logic                        nt_xcvr_reset_out,
	output var  logic                        nt_startup_out,
	output var  logic                        loop_out,
	output var  logic [span_pkg::IND_W-1:0]  nt_ind_out,
	output var  logic [span_pkg::PID_W-1:0]  nt_pid_out,
	output var  logic [span_pkg::DATA_W-1:0] nt_data_out,
	output var  logic                        nt_eoc_valid_out,
	output var  logic [span_pkg::ADDR_W-1:0] nt_eoc_addr_out,
	output var  logic [span_pkg::CODE_W-1:0] nt_eoc_code_out
);
	typedef enum logic {ST_OFF, ST_RUN} reg_state_t;

	reg_state_t state_r;
	reg_state_t state_nxt;
	logic       loop_r;
	logic       restart_r;
	logic       loss_fire;

	// ----------------------------------------------------------------
	// Loss persistence
	// ----------------------------------------------------------------
	wire loss_any = lt_signal_loss_in || lt_frame_alignment_loss_in ||
		nt_signal_loss_in || nt_frame_alignment_loss_in; // [RL2]

	loss_timer #(
		.CYCLES (LOSS_CYCLES)
	) u_loss (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.cond_in     (loss_any),
		.expired_out (loss_fire)
	);

	// ----------------------------------------------------------------
	// Message decode
	// ----------------------------------------------------------------
	wire run      = state_r == ST_RUN;
	wire own_addr = span.eoc_dn_addr == span_pkg::REG_ADDR;
	wire hit_reg  = run && span.eoc_dn_valid && own_addr; // [RL9]
	wire foreign  = run && span.eoc_dn_valid && !own_addr;
	wire cmd_loop = hit_reg && span.eoc_dn_code == span_pkg::CMD_LOOP1A;
	wire cmd_norm = hit_reg && span.eoc_dn_code == span_pkg::CMD_NORMAL;
	wire drop_nt  = cmd_norm && loop_r; // [RL12]
	// A new start-up from the line terminal wakes a shut-down span
	wire wake     = !run && span.startup_sig && !loss_any;
	wire start_nt = wake || (restart_r && lt_link_active_in); // [RL13]
	wire hold_rsp = foreign && loop_r; // [RL10]
	wire fwd_up   = run && !loop_r && nt_eoc_valid_in;

	// Loss shutdown outranks a wake in the same cycle
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_OFF: begin
				if (wake && !loss_fire) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (loss_fire) begin
					state_nxt = ST_OFF; // [RL2]
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Payload and indicator selection
	// ----------------------------------------------------------------
	// Loop returns the line terminal's own bits; the network side is
	// fed the same stream in both modes, so the loop stays transparent
	wire [span_pkg::IND_W-1:0]  ind_src  = loop_r ? span.ind_dn
		: nt_ind_in; // [RL11]
	wire [span_pkg::IND_W-1:0]  ind_nxt  = {reg_bits_in,
		ind_src[span_pkg::REG_BITS_LO-1:0]}; // [RL14]
	wire [span_pkg::PID_W-1:0]  pid_nxt  = loop_r ? span.pid_dn
		: nt_pid_in;
	wire [span_pkg::DATA_W-1:0] data_nxt = loop_r ? span.data_dn
		: nt_data_in;
	wire [span_pkg::ADDR_W-1:0] up_addr  = fwd_up && !hit_reg
		&& !hold_rsp ? nt_eoc_addr_in : span_pkg::REG_ADDR;
	wire [span_pkg::CODE_W-1:0] up_code  = hold_rsp ? span_pkg::CMD_HOLD
		: (hit_reg ? span.eoc_dn_code : nt_eoc_code_in);

	// ----------------------------------------------------------------
	// Control state
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			state_r           <= ST_OFF;
			restart_r         <= 1'b0;
			nt_side_on_out    <= 1'b0;
			nt_xcvr_reset_out <= 1'b0;
			nt_startup_out    <= 1'b0;
			span.line_on      <= 1'b0;
		end else begin
			state_r <= state_nxt; // [RL1]
			// Active link: retrain customer side under loop conditions
			nt_xcvr_reset_out <= cmd_loop && !loop_r
				&& nt_link_active_in; // [RL6]
			restart_r      <= drop_nt && !loss_fire;
			nt_side_on_out <= !loss_fire && (start_nt
				|| (nt_side_on_out && !drop_nt)); // [RL2]
			nt_startup_out <= !loss_fire && start_nt; // [RL13]
			span.line_on   <= state_nxt == ST_RUN; // [RL2]
		end
	end

	// ----------------------------------------------------------------
	// Loopback flag
	// ----------------------------------------------------------------
	// One flag only, so a loss shutdown cannot leave a stale loop behind
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || loss_fire) begin
			loop_r <= 1'b0; // [RL15]
		end else if (cmd_loop) begin
			loop_r <= 1'b1; // [RL5]
		end else if (cmd_norm) begin
			loop_r <= 1'b0; // [RL12]
		end
	end

	// ----------------------------------------------------------------
	// Data paths
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || !run) begin
			span.ind_up  <= '0;
			span.pid_up  <= '0;
			span.data_up <= '0;
			nt_ind_out   <= '0;
			nt_pid_out   <= '0;
			nt_data_out  <= '0;
		end else begin
			span.ind_up  <= ind_nxt; // [RL11]
			span.pid_up  <= pid_nxt;
			span.data_up <= data_nxt;
			nt_ind_out   <= span.ind_dn; // [RL7]
			nt_pid_out   <= span.pid_dn;
			nt_data_out  <= span.data_dn; // [RL7]
		end
	end

	// ----------------------------------------------------------------
	// Operations channel
	// ----------------------------------------------------------------
	// Own-address messages are answered here and never reach the
	// network side; a network reply in the same cycle is dropped
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			span.eoc_up_valid <= 1'b0;
			span.eoc_up_addr  <= '0;
			span.eoc_up_code  <= '0;
			nt_eoc_valid_out  <= 1'b0;
			nt_eoc_addr_out   <= '0;
			nt_eoc_code_out   <= '0;
			loop_out          <= 1'b0;
		end else begin
			span.eoc_up_valid <= hit_reg || hold_rsp || fwd_up; // [RL9]
			span.eoc_up_addr  <= up_addr; // [RL10]
			span.eoc_up_code  <= up_code;
			nt_eoc_valid_out  <= foreign && !loop_r; // [RL9]
			nt_eoc_addr_out   <= span.eoc_dn_addr;
			nt_eoc_code_out   <= span.eoc_dn_code;
			loop_out          <= loss_fire ? 1'b0
				: (cmd_loop || (loop_r && !cmd_norm));
		end
	end
endmodule
`default_nettype wire

// *** rtl/span_if.sv ***
// Span between line terminal and regenerator.
// Both ends drive their signals from flip-flops on the common clock.
`timescale 1ns/100ps
`default_nettype none
interface span_if;
	// Line terminal toward regenerator
	logic                        startup_sig;
	logic                        eoc_dn_valid;
	logic [span_pkg::ADDR_W-1:0] eoc_dn_addr;
	logic [span_pkg::CODE_W-1:0] eoc_dn_code;
	logic [span_pkg::IND_W-1:0]  ind_dn;
	logic [span_pkg::PID_W-1:0]  pid_dn;
	logic [span_pkg::DATA_W-1:0] data_dn;
	// Regenerator toward line terminal
	logic                        line_on;
	logic                        eoc_up_valid;
	logic [span_pkg::ADDR_W-1:0] eoc_up_addr;
	logic [span_pkg::CODE_W-1:0] eoc_up_code;
	logic [span_pkg::IND_W-1:0]  ind_up;
	logic [span_pkg::PID_W-1:0]  pid_up;
	logic [span_pkg::DATA_W-1:0] data_up;

	modport reg_end (
		input  startup_sig, eoc_dn_valid, eoc_dn_addr, eoc_dn_code,
		input  ind_dn, pid_dn, data_dn,
		output line_on, eoc_up_valid, eoc_up_addr, eoc_up_code,
		output ind_up, pid_up, data_up
	);
	modport lt_end (
		output startup_sig, eoc_dn_valid, eoc_dn_addr, eoc_dn_code,
		output ind_dn, pid_dn, data_dn,
		input  line_on, eoc_up_valid, eoc_up_addr, eoc_up_code,
		input  ind_up, pid_up, data_up
	);
endinterface
`default_nettype wire

// *** rtl/span_pkg.sv ***
// Shared constants for the regenerator and line terminal controllers.
// Assumes one 100 MHz clock shared by both ends.
package span_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ      = 100_000_000;
	localparam int unsigned LOSS_TIME_S = 2;
	localparam logic [31:0] LOSS_CYCLES = 32'(LOSS_TIME_S * CLK_HZ);

	// ----------------------------------------------------------------
	// Widths of the span signals
	// ----------------------------------------------------------------
	localparam int ADDR_W = 2;
	localparam int CODE_W = 4;
	localparam int IND_W  = 8;
	localparam int PID_W  = 2;
	localparam int DATA_W = 8;

	// ----------------------------------------------------------------
	// Operations channel addresses and messages
	// ----------------------------------------------------------------
	localparam logic [1:0] REG_ADDR   = 2'h2;
	localparam logic [1:0] NT_ADDR    = 2'h1;
	localparam logic [3:0] CMD_LOOP1A = 4'h1;
	localparam logic [3:0] CMD_NORMAL = 4'h2;
	localparam logic [3:0] CMD_HOLD   = 4'h3;

	// ----------------------------------------------------------------
	// Indicator bits and path identification
	// ----------------------------------------------------------------
	localparam int PS1_BIT     = 0;
	localparam int PS2_BIT     = 1;
	localparam int REG_BITS_LO = 4;
	localparam int REG_BITS_W  = 4;
	localparam logic [1:0] PID_LT = 2'h1;
	localparam logic [1:0] PID_NT = 2'h2;

	// ----------------------------------------------------------------
	// Line terminal software registers
	// ----------------------------------------------------------------
	localparam int BUS_AW = 4;
	localparam int BUS_DW = 8;
	localparam logic [3:0] REG_CTRL  = 4'h0;
	localparam logic [3:0] REG_CMD   = 4'h1;
	localparam logic [3:0] REG_STAT  = 4'h2;
	localparam logic [3:0] REG_MASK  = 4'h3;
	localparam logic [3:0] REG_REPLY = 4'h4;
	localparam logic [3:0] REG_IND   = 4'h5;
	localparam int CTRL_START  = 0;
	localparam int CMD_ADDR_LO = 4;
	localparam int STAT_W      = 5;
	localparam int ST_LOOP_OK  = 0;
	localparam int ST_PS1      = 1;
	localparam int ST_PS2      = 2;
	localparam int ST_REPLY    = 3;
	localparam int ST_LOSS     = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [4:0] STAT_RESET = 5'h00;
	localparam logic [4:0] MASK_RESET = 5'h00;
endpackage
